// >>> dacr_regbank.sv
// configuration register bank with serial configuration port
//
// Contract
// RL1: clock divide code 00 and 10 divide by one, 01 by two, 11 by four
// RL2: skew code delays sync reference 60 ps per step, 0 to 420 ps
// RL3: channel A power-down bit set stops channel A, clear runs it
// RL4: channel B power-down bit set stops channel B, clear runs it
// RL5: sleep bit stops both converters, clock and output buffers stay on
// RL6: format bit zero gives twos complement, one gives offset binary
// RL7: controller always writes one to bit three of power register
// RL8: writing the software reset bit restores all defaults, bit self-clears
// RL9: power register and other bank registers reset to zero
// RL10: channel A gain apply bit enables gain path, clear bypasses it
// RL11: controller sets channel A apply bit before writing its gain code
// RL12: gain codes 3..19 give -2..6 dB by half dB, zero is 0 dB
// RL13: above 250 MHz input controller writes 90h to both tuning registers
// RL14: channel B gain register mirrors channel A layout and behaviour
// RL15: controller writes zero to reserved bits, ignores their readback; the bench compares whole read bytes, reserved bits included
// RL16: read-write fields read back last written value or reset default
`timescale 1ns/1ps
module dacr_regbank (
  // clock and reset
  input wire logic i_clk_sys,
  input wire logic i_rst_n,
  // serial configuration pins
  input wire logic i_sen_n,
  input wire logic i_sclk,
  input wire logic i_sdio,
  output logic o_sdout,
  output logic o_sdout_oe,
  // clock path controls
  output logic [1:0] o_clk_div,
  output logic [2:0] o_clk_div_ratio,
  output logic [2:0] o_sync_ref_skew,
  output logic [8:0] o_sync_ref_skew_ps,
  // power and format controls
  output logic o_conv_on_a,
  output logic o_conv_on_b,
  output logic o_clk_buf_on,
  output logic o_out_buf_on,
  output logic o_offset_binary,
  // digital gain controls, signed half dB units
  output logic o_gain_apply_a,
  output logic signed [5:0] o_gain_half_db_a,
  output logic o_gain_apply_b,
  output logic signed [5:0] o_gain_half_db_b,
  // high frequency mode
  output logic [1:0] o_hf_tune_one,
  output logic [1:0] o_hf_tune_two,
  output logic o_hf_mode_on
);

  typedef struct packed {
    dacr_pkg::dacr_cfg_t cfg;
    logic sclk_d;
    logic [4:0] bit_cnt;
    logic [14:0] shift_in;
    logic read_mode;
    logic [7:0] shift_out;
    logic sdout;
    logic sdout_oe;
    logic [2:0] div_ratio;
    logic [8:0] skew_ps;
    logic conv_on_a;
    logic conv_on_b;
    logic bufs_on;
    logic signed [5:0] gain_a;
    logic signed [5:0] gain_b;
    logic hf_on;
  } dacr_state_t;

  localparam dacr_state_t STATE_RST = '0;

  dacr_state_t state_r;
  dacr_state_t state_nxt;
  logic [2:0] pins_s;
  logic sen_n_s;
  logic sclk_s;
  logic sdio_s;

  // all three pins are asynchronous to the system clock
  dacr_sync #(
    .W(3)
  ) u_pin_sync (
    .i_clk_sys(i_clk_sys),
    .i_rst_n(i_rst_n),
    .i_async({i_sen_n, i_sclk, i_sdio}),
    .o_sync(pins_s)
  );

  assign sen_n_s = pins_s[2];
  assign sclk_s = pins_s[1];
  assign sdio_s = pins_s[0];

  // read data; write-only and reserved bits read as zero
  function automatic logic [7:0] read_word(input dacr_pkg::dacr_cfg_t c,
                                           input logic [7:0] addr);
    logic [7:0] d;
    d = 8'h00;
    case (addr)
      dacr_pkg::DACR_OFF_CLK_DIV: d[1:0] = c.clk_div; // [RL16]
      dacr_pkg::DACR_OFF_SKEW: d[2:0] = c.sync_ref_skew; // [RL16]
      dacr_pkg::DACR_OFF_PWR_FMT:
      begin
        d[dacr_pkg::DACR_POS_PDN_A] = c.power_down_a;
        d[dacr_pkg::DACR_POS_PDN_B] = c.power_down_b;
        d[dacr_pkg::DACR_POS_SLEEP] = c.both_converters_sleep;
        d[dacr_pkg::DACR_POS_FMT] = c.offset_binary;
      end
      dacr_pkg::DACR_OFF_GAIN_A:
      begin
        d[7:3] = c.gain_code_a;
        d[dacr_pkg::DACR_POS_GAIN_EN] = c.gain_apply_a;
      end
      dacr_pkg::DACR_OFF_GAIN_B:
      begin
        d[7:3] = c.gain_code_b; // [RL14]
        d[dacr_pkg::DACR_POS_GAIN_EN] = c.gain_apply_b;
      end
      dacr_pkg::DACR_OFF_HF_ONE:
      begin
        d[dacr_pkg::DACR_POS_HF_HI] = c.hf_tune_one[1];
        d[dacr_pkg::DACR_POS_HF_LO] = c.hf_tune_one[0];
      end
      dacr_pkg::DACR_OFF_HF_TWO:
      begin
        d[dacr_pkg::DACR_POS_HF_HI] = c.hf_tune_two[1];
        d[dacr_pkg::DACR_POS_HF_LO] = c.hf_tune_two[0];
      end
      default: d = 8'h00;
    endcase
    return d;
  endfunction

  // gain code to signed half dB; unused codes fall back to 0 dB
  function automatic logic signed [5:0] gain_map(input logic en,
                                                 input logic [4:0] code);
    logic signed [5:0] g;
    g = 6'sh00;
    if (en && code >= dacr_pkg::DACR_GAIN_MIN
        && code <= dacr_pkg::DACR_GAIN_MAX)
    begin
      g = $signed({1'b0, code} - dacr_pkg::DACR_GAIN_ZERO_DB); // [RL12]
    end
    return g;
  endfunction

  // serial shifting, register writes and decoded controls
  always_comb
  begin
    logic rise;
    logic fall;
    logic [15:0] word;
    logic [7:0] addr;
    rise = 1'b0;
    fall = 1'b0;
    word = 16'h0000;
    addr = 8'h00;
    state_nxt = state_r;
    state_nxt.sclk_d = sclk_s;
    rise = sclk_s & ~state_r.sclk_d;
    fall = ~sclk_s & state_r.sclk_d;
    word = {state_r.shift_in, sdio_s};
    // address bit six is ignored; only six address bits select
    addr = {2'h0, word[13:8]};
    if (sen_n_s)
    begin
      // frame over: release the data pin and rearm
      state_nxt.bit_cnt = 5'h00;
      state_nxt.read_mode = 1'b0;
      state_nxt.sdout_oe = 1'b0;
      state_nxt.sdout = 1'b0;
    end
    else if (rise && state_r.bit_cnt < dacr_pkg::DACR_FRAME_BITS)
    begin
      state_nxt.shift_in = word[14:0];
      state_nxt.bit_cnt = state_r.bit_cnt + 5'h01;
      if (state_r.bit_cnt == dacr_pkg::DACR_ADDR_LAST)
      begin
        state_nxt.read_mode = word[dacr_pkg::DACR_POS_READ];
        state_nxt.shift_out = read_word(state_r.cfg,
                                        {2'h0, word[5:0]});
      end
      if (state_r.bit_cnt == dacr_pkg::DACR_FRAME_LAST
          && !state_r.read_mode)
      begin
        case (addr)
          dacr_pkg::DACR_OFF_CLK_DIV:
            state_nxt.cfg.clk_div = word[1:0];
          dacr_pkg::DACR_OFF_SKEW:
            state_nxt.cfg.sync_ref_skew = word[2:0];
          dacr_pkg::DACR_OFF_PWR_FMT:
          begin
            // bit three is write-only and has no effect here
            state_nxt.cfg.power_down_a = word[dacr_pkg::DACR_POS_PDN_A];
            state_nxt.cfg.power_down_b = word[dacr_pkg::DACR_POS_PDN_B];
            state_nxt.cfg.both_converters_sleep =
              word[dacr_pkg::DACR_POS_SLEEP];
            state_nxt.cfg.offset_binary = word[dacr_pkg::DACR_POS_FMT];
            if (word[dacr_pkg::DACR_POS_SW_RST])
            begin
              // reset bit is never stored, so it reads back zero
              state_nxt.cfg = dacr_pkg::DACR_CFG_RST; // [RL8]
            end
          end
          dacr_pkg::DACR_OFF_GAIN_A:
          begin
            state_nxt.cfg.gain_code_a = word[7:3];
            state_nxt.cfg.gain_apply_a = word[dacr_pkg::DACR_POS_GAIN_EN];
          end
          dacr_pkg::DACR_OFF_GAIN_B:
          begin
            state_nxt.cfg.gain_code_b = word[7:3]; // [RL14]
            state_nxt.cfg.gain_apply_b = word[dacr_pkg::DACR_POS_GAIN_EN];
          end
          dacr_pkg::DACR_OFF_HF_ONE:
            state_nxt.cfg.hf_tune_one = {word[dacr_pkg::DACR_POS_HF_HI],
                                         word[dacr_pkg::DACR_POS_HF_LO]};
          dacr_pkg::DACR_OFF_HF_TWO:
            state_nxt.cfg.hf_tune_two = {word[dacr_pkg::DACR_POS_HF_HI],
                                         word[dacr_pkg::DACR_POS_HF_LO]};
          default: state_nxt.cfg = state_r.cfg;
        endcase
      end
    end
    else if (fall && state_r.read_mode
             && state_r.bit_cnt > dacr_pkg::DACR_ADDR_LAST
             && state_r.bit_cnt < dacr_pkg::DACR_FRAME_BITS)
    begin
      // data leaves on falling edges so the controller samples on rising
      state_nxt.sdout = state_r.shift_out[7];
      state_nxt.shift_out = {state_r.shift_out[6:0], 1'b0};
      state_nxt.sdout_oe = 1'b1;
    end

    // decoded controls follow the stored fields one cycle later
    case (state_r.cfg.clk_div)
      dacr_pkg::DACR_DIV_BYPASS:
        state_nxt.div_ratio = dacr_pkg::DACR_RATIO_1; // [RL1]
      dacr_pkg::DACR_DIV_TWO:
        state_nxt.div_ratio = dacr_pkg::DACR_RATIO_2; // [RL1]
      dacr_pkg::DACR_DIV_ONE:
        state_nxt.div_ratio = dacr_pkg::DACR_RATIO_1; // [RL1]
      dacr_pkg::DACR_DIV_FOUR:
        state_nxt.div_ratio = dacr_pkg::DACR_RATIO_4; // [RL1]
      default: state_nxt.div_ratio = dacr_pkg::DACR_RATIO_1;
    endcase
    // widen both factors first: code 7 gives 420, past six bits
    state_nxt.skew_ps = 9'(state_r.cfg.sync_ref_skew)
                        * 9'(dacr_pkg::DACR_SKEW_STEP_PS); // [RL2]
    state_nxt.conv_on_a = ~state_r.cfg.power_down_a
                          & ~state_r.cfg.both_converters_sleep; // [RL3] [RL5]
    state_nxt.conv_on_b = ~state_r.cfg.power_down_b
                          & ~state_r.cfg.both_converters_sleep; // [RL4] [RL5]
    // buffers stay alive in sleep so the device wakes quickly
    state_nxt.bufs_on = 1'b1; // [RL5]
    state_nxt.gain_a = gain_map(state_r.cfg.gain_apply_a,
                                state_r.cfg.gain_code_a); // [RL10] [RL12]
    state_nxt.gain_b = gain_map(state_r.cfg.gain_apply_b,
                                state_r.cfg.gain_code_b); // [RL14]
    state_nxt.hf_on = ({state_r.cfg.hf_tune_one, state_r.cfg.hf_tune_two}
                       == 4'hf);
  end

  // single state register; everything clears to zero
  always_ff @(posedge i_clk_sys or negedge i_rst_n)
  begin
    if (!i_rst_n)
      state_r <= STATE_RST; // [RL9]
    else
      state_r <= state_nxt;
  end

  // outputs come straight from the state register
  assign o_sdout = state_r.sdout;
  assign o_sdout_oe = state_r.sdout_oe;
  assign o_clk_div = state_r.cfg.clk_div;
  assign o_clk_div_ratio = state_r.div_ratio;
  assign o_sync_ref_skew = state_r.cfg.sync_ref_skew;
  assign o_sync_ref_skew_ps = state_r.skew_ps;
  assign o_conv_on_a = state_r.conv_on_a;
  assign o_conv_on_b = state_r.conv_on_b;
  assign o_clk_buf_on = state_r.bufs_on;
  assign o_out_buf_on = state_r.bufs_on;
  assign o_offset_binary = state_r.cfg.offset_binary; // [RL6]
  assign o_gain_apply_a = state_r.cfg.gain_apply_a; // [RL10]
  assign o_gain_half_db_a = state_r.gain_a;
  assign o_gain_apply_b = state_r.cfg.gain_apply_b;
  assign o_gain_half_db_b = state_r.gain_b;
  assign o_hf_tune_one = state_r.cfg.hf_tune_one;
  assign o_hf_tune_two = state_r.cfg.hf_tune_two;
  assign o_hf_mode_on = state_r.hf_on;

endmodule

// >>> dacr_pkg.sv
// shared constants and types for the dual converter configuration bank
package dacr_pkg;

  // register offsets on the serial configuration port
  localparam logic [7:0] DACR_OFF_CLK_DIV = 8'h06;
  localparam logic [7:0] DACR_OFF_SKEW = 8'h07;
  localparam logic [7:0] DACR_OFF_PWR_FMT = 8'h08;
  localparam logic [7:0] DACR_OFF_GAIN_A = 8'h0b;
  localparam logic [7:0] DACR_OFF_GAIN_B = 8'h0c;
  localparam logic [7:0] DACR_OFF_HF_ONE = 8'h0d;
  localparam logic [7:0] DACR_OFF_HF_TWO = 8'h0e;

  // field positions
  localparam int DACR_POS_PDN_A = 7;
  localparam int DACR_POS_PDN_B = 6;
  localparam int DACR_POS_SLEEP = 5;
  localparam int DACR_POS_FMT = 4;
  localparam int DACR_POS_SW_RST = 0;
  localparam int DACR_POS_GAIN_EN = 2;
  localparam int DACR_POS_GAIN_LSB = 3;
  localparam int DACR_POS_HF_HI = 7;
  localparam int DACR_POS_HF_LO = 4;
  localparam int DACR_POS_READ = 7;

  // serial frame layout: read flag, address, then data, msb first
  localparam logic [4:0] DACR_ADDR_LAST = 5'h07;
  localparam logic [4:0] DACR_FRAME_LAST = 5'h0f;
  localparam logic [4:0] DACR_FRAME_BITS = 5'h10;

  // clock divide codes and resulting ratios
  localparam logic [1:0] DACR_DIV_BYPASS = 2'h0;
  localparam logic [1:0] DACR_DIV_TWO = 2'h1;
  localparam logic [1:0] DACR_DIV_ONE = 2'h2;
  localparam logic [1:0] DACR_DIV_FOUR = 2'h3;
  localparam logic [2:0] DACR_RATIO_1 = 3'h1;
  localparam logic [2:0] DACR_RATIO_2 = 3'h2;
  localparam logic [2:0] DACR_RATIO_4 = 3'h4;

  // sync reference skew, picoseconds per code step
  localparam logic [5:0] DACR_SKEW_STEP_PS = 6'h3c;

  // gain codes: zero is 0 dB, 3..19 span -2 dB..6 dB in half dB steps
  localparam logic [4:0] DACR_GAIN_MIN = 5'h03;
  localparam logic [4:0] DACR_GAIN_MAX = 5'h13;
  localparam logic [5:0] DACR_GAIN_ZERO_DB = 6'h07;

  // value recommended for both high frequency tuning registers
  localparam logic [7:0] DACR_HF_RECOMMENDED = 8'h90;

  // configuration fields held by the bank
  typedef struct packed {
    logic [1:0] clk_div;
    logic [2:0] sync_ref_skew;
    logic power_down_a;
    logic power_down_b;
    logic both_converters_sleep;
    logic offset_binary;
    logic gain_apply_a;
    logic [4:0] gain_code_a;
    logic gain_apply_b;
    logic [4:0] gain_code_b;
    logic [1:0] hf_tune_one;
    logic [1:0] hf_tune_two;
  } dacr_cfg_t;

  localparam dacr_cfg_t DACR_CFG_RST = '0;

endpackage

// >>> dacr_sync.sv
// two flip-flop synchroniser for asynchronous pin inputs
`timescale 1ns/1ps
module dacr_sync #(
  parameter int W = 1
) (
  // clock and reset
  input wire logic i_clk_sys,
  input wire logic i_rst_n,
  // asynchronous in, synchronous out
  input wire logic [W-1:0] i_async,
  output logic [W-1:0] o_sync
);

  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] sync;
  } dacr_sync_state_t;

  dacr_sync_state_t state_r;
  dacr_sync_state_t state_nxt;

  // first stage feeds only the second stage
  always_comb
  begin
    state_nxt.meta = i_async;
    state_nxt.sync = state_r.meta;
  end

  // both stages clear together; the first is never read outside
  always_ff @(posedge i_clk_sys or negedge i_rst_n)
  begin
    if (!i_rst_n)
      state_r <= '0;
    else
      state_r <= state_nxt;
  end

  assign o_sync = state_r.sync;

endmodule

// >>> dacr_regbank_checker.sv
// concurrent checks on the configuration bank's ports
`timescale 1ns/1ps
module dacr_regbank_checker (
  // clock, reset and serial pins
  input wire logic i_clk_sys, i_rst_n, i_sen_n, i_sclk, i_sdio,
  input wire logic o_sdout, o_sdout_oe,
  // clock path
  input wire logic [1:0] o_clk_div,
  input wire logic [2:0] o_clk_div_ratio, o_sync_ref_skew,
  input wire logic [8:0] o_sync_ref_skew_ps,
  // power, format and gain
  input wire logic o_conv_on_a, o_conv_on_b, o_clk_buf_on, o_out_buf_on,
  input wire logic o_offset_binary, o_gain_apply_a, o_gain_apply_b,
  input wire logic signed [5:0] o_gain_half_db_a, o_gain_half_db_b,
  // high frequency mode
  input wire logic [1:0] o_hf_tune_one, o_hf_tune_two,
  input wire logic o_hf_mode_on
);
  default clocking @(posedge i_clk_sys); endclocking
  default disable iff (!i_rst_n);
  // enable held high long enough for the synchroniser to settle
  sequence s_quiet;
    i_sen_n [*8];
  endsequence
  // decoded outputs lag their field by one cycle, so wait for stability
  property p_ratio;
    $past(i_rst_n) && $stable(o_clk_div) |-> o_clk_div_ratio ==
      (o_clk_div == 2'h3 ? 3'h4 : o_clk_div == 2'h1 ? 3'h2 : 3'h1);
  endproperty
  property p_skew;
    $stable(o_sync_ref_skew) |->
      o_sync_ref_skew_ps == 9'(o_sync_ref_skew) * 9'h03c;
  endproperty
  property p_bufs;
    $past(i_rst_n) |-> o_clk_buf_on && o_out_buf_on;
  endproperty
  property p_hf;
    $stable(o_hf_tune_one) && $stable(o_hf_tune_two) |->
      o_hf_mode_on == (&{o_hf_tune_one, o_hf_tune_two});
  endproperty
  property p_gain_a;
    o_gain_half_db_a != 6'sh00 |-> ($past(o_gain_apply_a) || o_gain_apply_a)
      && o_gain_half_db_a >= -6'sh04 && o_gain_half_db_a <= 6'sh0c;
  endproperty
  property p_gain_b;
    o_gain_half_db_b != 6'sh00 |-> ($past(o_gain_apply_b) || o_gain_apply_b)
      && o_gain_half_db_b >= -6'sh04 && o_gain_half_db_b <= 6'sh0c;
  endproperty
  property p_idle;
    s_quiet |-> !o_sdout_oe && !o_sdout;
  endproperty
  property p_hold;
    s_quiet |=> $stable({o_clk_div, o_sync_ref_skew, o_conv_on_a,
      o_conv_on_b, o_offset_binary, o_gain_apply_a, o_gain_apply_b,
      o_hf_tune_one, o_hf_tune_two});
  endproperty
  a_ratio: assert property (p_ratio) else $error("bad divide ratio");
  a_skew: assert property (p_skew) else $error("bad skew delay");
  a_bufs: assert property (p_bufs) else $error("buffers off");
  a_hf: assert property (p_hf) else $error("bad hf mode");
  a_gain_a: assert property (p_gain_a) else $error("bad gain a");
  a_gain_b: assert property (p_gain_b) else $error("bad gain b");
  a_idle: assert property (p_idle) else $error("sdout driven idle");
  a_hold: assert property (p_hold) else $error("config moved");
endmodule

bind dacr_regbank dacr_regbank_checker i_dacr_regbank_checker (.*);

// >>> dacr_ctrl_model.sv
// serial configuration controller model driving the bank's pins
`timescale 1ns/1ps
module dacr_ctrl_model (
  // clock
  input wire logic i_clk_sys,
  // read data wire from the bank
  input wire logic i_sdout,
  input wire logic i_sdout_oe,
  // serial pins towards the bank
  output logic o_sen_n,
  output logic o_sclk,
  output logic o_sdio
);
  // 120 ns half period leaves room for the readback lag
  localparam int HALF = 6;
  // idle: not selected, serial clock standing low
  initial
  begin
    o_sen_n = 1'b1;
    o_sclk = 1'b0;
    o_sdio = 1'b0;
  end
  // one frame: read flag, ignored bit, six address bits, eight data bits
  task automatic xfer(input logic rd, input logic [7:0] a,
    input logic [7:0] d, output logic [7:0] q, output logic oe);
    logic [15:0] f;
    f = {rd, 1'b0, a[5:0], d};
    if (!rd && a == 8'h08)
      f[3] = 1'b1;
    q = 8'h00;
    oe = 1'b1;
    @(posedge i_clk_sys);
    o_sen_n <= 1'b0;
    for (int i = 15; i >= 0; i--)
    begin
      o_sdio <= f[i];
      repeat (HALF) @(posedge i_clk_sys);
      o_sclk <= 1'b1;
      q = (i < 8) ? {q[6:0], i_sdout} : q;
      oe = (i < 8) ? (oe & i_sdout_oe) : oe;
      repeat (HALF) @(posedge i_clk_sys);
      o_sclk <= 1'b0;
    end
    repeat (HALF) @(posedge i_clk_sys);
    o_sen_n <= 1'b1;
    o_sdio <= ~f[0]; // released line must not keep the last bit
    repeat (HALF) @(posedge i_clk_sys);
  endtask
endmodule

// >>> test_dacr_regbank.sv
// self-checking bench for the configuration register bank
`timescale 1ns/1ps
module test_dacr_regbank;
  logic i_clk_sys = 1'b0;
  logic i_rst_n = 1'b0;
  logic i_sen_n, i_sclk, i_sdio, o_sdout, o_sdout_oe, sdout_w;
  logic tog = 1'b0;
  logic [1:0] o_clk_div, o_hf_tune_one, o_hf_tune_two;
  logic [2:0] o_clk_div_ratio, o_sync_ref_skew;
  logic [8:0] o_sync_ref_skew_ps;
  logic o_conv_on_a, o_conv_on_b, o_clk_buf_on, o_out_buf_on;
  logic o_offset_binary, o_gain_apply_a, o_gain_apply_b, o_hf_mode_on;
  logic signed [5:0] o_gain_half_db_a, o_gain_half_db_b;
  int failures = 0;
  int n_tests = 0;
  int cyc = 0;
  logic [7:0] offs [8] = '{8'h06, 8'h07, 8'h08, 8'h0b, 8'h0c, 8'h0d,
    8'h0e, 8'h0f};
  logic [7:0] pf [5] = '{8'h80, 8'h40, 8'h20, 8'h10, 8'hc0};
  logic [4:0] gc [5] = '{5'h00, 5'h03, 5'h07, 5'h13, 5'h0c};

  always #10 i_clk_sys = ~i_clk_sys;
  // undriven sdout wire shows a toggling pattern, not its last value
  always @(posedge i_clk_sys) tog <= ~tog;
  assign sdout_w = o_sdout_oe ? o_sdout : tog;

  dacr_regbank i_dacr_regbank (.*);
  dacr_ctrl_model i_dacr_ctrl_model (.i_clk_sys(i_clk_sys),
    .i_sdout(sdout_w), .i_sdout_oe(o_sdout_oe), .o_sen_n(i_sen_n),
    .o_sclk(i_sclk), .o_sdio(i_sdio));

  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [8:0] e,
    input logic [8:0] g);
    n_tests++;
    if (g !== e)
    begin
      failures++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [7:0] q;
    logic oe;
    i_dacr_ctrl_model.xfer(1'b0, a, d, q, oe);
  endtask
  task automatic rd(input string nm, input logic [7:0] a,
    input logic [7:0] e);
    logic [7:0] q;
    logic oe;
    i_dacr_ctrl_model.xfer(1'b1, a, 8'h00, q, oe);
    chk({nm, " oe"}, 9'h1, 9'(oe));
    chk(nm, 9'(e), 9'(q));
  endtask

  // hang guard: the whole sequence needs about 20000 cycles
  always @(posedge i_clk_sys)
  begin
    cyc++;
    if (cyc == 40000)
    begin
      failures++;
      give_verdict();
    end
  end

  // main sequence
  initial
  begin
    logic [7:0] p;
    logic [5:0] e6;
    logic [5:0] hd;
    repeat (20) @(posedge i_clk_sys);
    i_rst_n <= 1'b1;
    repeat (4) @(posedge i_clk_sys);
    foreach (offs[k]) rd("reset value", offs[k], 8'h00);
    chk("ratio", 9'h1, 9'(o_clk_div_ratio));
    chk("conv on", 9'h3, {7'h0, o_conv_on_a, o_conv_on_b});
    $display("test reset done");
    for (int c = 0; c < 4; c++)
    begin
      wr(8'h06, 8'(c));
      chk("ratio", c == 3 ? 9'h4 : c == 1 ? 9'h2 : 9'h1,
        9'(o_clk_div_ratio));
      chk("clk div", 9'(c), 9'(o_clk_div));
      rd("clk div", 8'h06, 8'(c));
    end
    for (int c = 0; c < 8; c++)
    begin
      wr(8'h07, 8'(c));
      chk("skew ps", 9'(c * 60), o_sync_ref_skew_ps);
      chk("skew", 9'(c), 9'(o_sync_ref_skew));
      rd("skew", 8'h07, 8'(c));
    end
    $display("test clock path done");
    foreach (pf[k])
    begin
      p = pf[k];
      wr(8'h08, p);
      chk("conv a", 9'(!(p[7] | p[5])), 9'(o_conv_on_a));
      chk("conv b", 9'(!(p[6] | p[5])), 9'(o_conv_on_b));
      chk("bufs", 9'h3, {7'h0, o_clk_buf_on, o_out_buf_on});
      chk("format", 9'(p[4]), 9'(o_offset_binary));
      rd("power", 8'h08, p);
    end
    $display("test power done");
    for (int ch = 0; ch < 2; ch++)
    begin
      foreach (gc[k])
      begin
        wr(8'h0b + 8'(ch), 8'h04);
        wr(8'h0b + 8'(ch), {gc[k], 3'h4});
        hd = ch ? o_gain_half_db_b : o_gain_half_db_a;
        e6 = gc[k] == 5'h0 ? 6'h0 : 6'({1'b0, gc[k]} - 6'h07);
        chk("half db", 9'(e6), 9'(hd));
        chk("apply", 9'h1, 9'(ch ? o_gain_apply_b : o_gain_apply_a));
        rd("gain", 8'h0b + 8'(ch), {gc[k], 3'h4});
      end
      wr(8'h0b + 8'(ch), 8'h98);
      hd = ch ? o_gain_half_db_b : o_gain_half_db_a;
      chk("bypass", 9'h0,
        {2'h0, hd, ch ? o_gain_apply_b : o_gain_apply_a});
    end
    $display("test gain done");
    wr(8'h0d, 8'h90);
    wr(8'h0e, 8'h90);
    chk("hf on", 9'h1, 9'(o_hf_mode_on));
    chk("hf tune", 9'hf, {5'h0, o_hf_tune_one, o_hf_tune_two});
    rd("hf one", 8'h0d, 8'h90);
    rd("hf two", 8'h0e, 8'h90);
    wr(8'h0e, 8'h10);
    chk("hf off", 9'h0, 9'(o_hf_mode_on));
    $display("test high frequency done");
    wr(8'h06, 8'h03);
    wr(8'h08, 8'hd0);
    wr(8'h08, 8'h01);
    foreach (offs[k]) rd("soft reset", offs[k], 8'h00);
    chk("ratio", 9'h1, 9'(o_clk_div_ratio));
    chk("conv on", 9'h3, {7'h0, o_conv_on_a, o_conv_on_b});
    $display("test soft reset done");
    give_verdict();
  end
endmodule
